// ### rtl/rwu_top.sv
// reset sequencer and watchdog timer with avalon-mm register slave
//
// The Avalon-MM interface to the registers was decided locally.
`default_nettype none
module rwu_top #(
  parameter logic [15:0] START_ADDR = 16'h0000
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        ext_reset_n_pin_i,
  input  wire logic                        lowspeed_clk_i,
  input  wire logic                        subclk_i,
  input  wire logic                        standby_i,
  input  wire logic                        deep_standby_i,
  input  wire logic [rwu_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [rwu_pkg::DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [rwu_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic      [1:0]                  avs_response_o,
  output logic                             avs_waitrequest_o,
  output logic                             sys_rst_n_o,
  output logic                             wdog_reset_o,
  output logic                             force_medrc_o,
  output logic                             pc_load_o,
  output logic      [15:0]                 pc_start_o,
  output logic      [15:0]                 sp_init_o,
  output logic                             lowspeed_osc_run_o,
  output logic                             subclk_osc_enable_o
);

  // reset sequencer states
  typedef enum logic {
    RWU_SEQ_HOLD,
    RWU_SEQ_RUN
  } rwu_seq_t;

  // whole unit state, one flop bank
  typedef struct packed {
    rwu_seq_t                            seq;
    logic [rwu_pkg::HOLD_W-1:0]          hold;
    logic                                sysrst_n;
    logic                                medrc;
    logic                                pc_load;
    logic [15:0]                         pc;
    logic [15:0]                         sp;
    logic                                wdrst;
    logic [rwu_pkg::REG_W-1:0]           ctrl;
    logic [rwu_pkg::REG_W-1:0]           osc;
    logic [rwu_pkg::CNT_W-1:0]           cnt;
    logic                                ls_q;
    logic                                sb_q;
    logic                                stby_q;
    logic                                hold_q;
    logic                                lsrun;
    logic                                waitreq;
    logic [rwu_pkg::DATA_W-1:0]          rdata;
    logic [1:0]                          resp;
  } rwu_state_t;

  localparam logic [rwu_pkg::HOLD_W-1:0] HOLD_LOAD =
    rwu_pkg::HOLD_W'(rwu_pkg::RST_HOLD_CYC);

  rwu_state_t r;
  rwu_state_t n;

  // synchronised pin and clock levels
  logic [2:0] sync_q;
  logic       ext_n_s;
  logic       ls_s;
  logic       sb_s;

  // byte address to register hit
  function automatic logic reg_hit(input logic [rwu_pkg::ADDR_W-1:0] a,
                                   input logic [15:0]                 idx);
    reg_hit = (a[1:0] == 2'h0) && (a[rwu_pkg::ADDR_W-1:2] == idx);
  endfunction

  // overflow count from select code
  function automatic logic [17:0] ovf_limit(input logic [2:0] sel);
    ovf_limit = rwu_pkg::OVF_BASE << sel;
  endfunction

  // standby action code selects stop
  function automatic logic act_stop(input logic [1:0] code);
    act_stop = (code == rwu_pkg::ACT_STOP);
  endfunction

  // pin and oscillator clocks enter through two flops
  rwu_sync #(
    .W       (3),
    .RST_VAL (3'h1)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .d_i       ({subclk_i, lowspeed_clk_i, ext_reset_n_pin_i}),
    .q_o       (sync_q)
  );

  assign ext_n_s = sync_q[0];
  assign ls_s    = sync_q[1];
  assign sb_s    = sync_q[2];

  always_comb begin
    logic                       req;
    logic                       acc_wr;
    logic                       hit_ctrl;
    logic                       hit_kick;
    logic                       hit_osc;
    logic                       hit_cnt;
    logic                       wr_ctrl;
    logic                       wr_kick;
    logic                       wr_osc;
    logic                       ext_low;
    logic                       run;
    logic                       cksl;
    logic [1:0]                 act;
    logic                       stop_sel;
    logic                       paused;
    logic                       tick;
    logic                       stby_entry;
    logic                       hold_entry;
    logic                       kick;
    logic                       sub_off;
    logic                       ovf;
    logic                       wd_evt;
    logic                       restart;
    logic [2:0]                 ovf_sel;
    logic [17:0]                limit;
    logic [17:0]                cnt_inc;
    logic [rwu_pkg::REG_W-1:0]  wbyte;
    n          = r;
    req        = avs_read_i | avs_write_i;
    acc_wr     = avs_write_i & ~r.waitreq & avs_byteenable_i[0];
    hit_ctrl   = reg_hit(avs_address_i, rwu_pkg::CTRL_IDX);
    hit_kick   = reg_hit(avs_address_i, rwu_pkg::KICK_IDX);
    hit_osc    = reg_hit(avs_address_i, rwu_pkg::OSC_IDX);
    hit_cnt    = reg_hit(avs_address_i, rwu_pkg::CNT_IDX);
    wr_ctrl    = acc_wr & hit_ctrl;
    wr_kick    = acc_wr & hit_kick;
    wr_osc     = acc_wr & hit_osc;
    wbyte      = avs_writedata_i[rwu_pkg::REG_W-1:0];
    ext_low    = ~ext_n_s;
    run        = r.ctrl[rwu_pkg::RUN_BIT];
    cksl       = r.ctrl[rwu_pkg::CKSL_BIT];
    act        = r.ctrl[rwu_pkg::ACT_HI_BIT:rwu_pkg::ACT_LO_BIT];
    stop_sel   = act_stop(act);
    paused     = standby_i & (act == rwu_pkg::ACT_PAUSE);
    tick       = 1'b0;
    stby_entry = standby_i & ~r.stby_q;
    hold_entry = deep_standby_i & ~r.hold_q;
    kick       = 1'b0;
    sub_off    = 1'b0;
    ovf        = 1'b0;
    wd_evt     = 1'b0;
    restart    = 1'b0;
    ovf_sel    = r.ctrl[rwu_pkg::OVF_HI_BIT:rwu_pkg::OVF_LO_BIT];
    limit      = ovf_limit(ovf_sel);
    cnt_inc    = {1'b0, r.cnt} + 18'h00001;
    n.wdrst    = 1'b0;
    n.pc_load  = 1'b0;
    n.ls_q     = ls_s;
    n.sb_q     = sb_s;
    n.stby_q   = standby_i;
    n.hold_q   = deep_standby_i;

    // bus slave: one wait cycle, then the access completes
    if (req && r.waitreq) begin
      n.waitreq = 1'b0;
      n.resp    = rwu_pkg::RESP_OKAY;
      n.rdata   = '0;
      if (hit_ctrl) begin
        n.rdata[rwu_pkg::REG_W-1:0] = r.ctrl;
      end else if (hit_osc) begin
        n.rdata[rwu_pkg::REG_W-1:0] = r.osc;
      end else if (hit_cnt) begin
        n.rdata[rwu_pkg::CNT_W-1:0] = r.cnt;
      end else if (!hit_kick) begin
        n.resp = rwu_pkg::RESP_SLVERR;
      end
    end else begin
      n.waitreq = 1'b1;
    end

    // software writes
    if (wr_ctrl && !run) begin
      n.ctrl = wbyte;
    end
    if (wr_kick && run && wbyte == rwu_pkg::KICK_CODE) begin
      kick = 1'b1;
    end
    if (wr_osc) begin
      n.osc   = wbyte;
      sub_off = r.osc[rwu_pkg::SUB_EN_BIT] & ~wbyte[rwu_pkg::SUB_EN_BIT];
    end

    // counter on the selected watchdog clock
    if (cksl) begin
      tick = sb_s & ~r.sb_q;
    end else begin
      tick = ls_s & ~r.ls_q;
    end
    if (kick) begin
      n.cnt = '0;
    end else if (run && !paused && tick) begin
      if (cnt_inc == limit) begin
        ovf = 1'b1;
      end else begin
        n.cnt = cnt_inc[rwu_pkg::CNT_W-1:0];
      end
    end

    // standby with stop action halts the watchdog
    if (run && stby_entry && stop_sel) begin
      n.ctrl[rwu_pkg::RUN_BIT] = 1'b0;
    end

    // overflow, or subclock lost or deep standby while running on it
    wd_evt = ovf | (run & cksl & ~stop_sel &
                    (sub_off | hold_entry));
    if (wd_evt) begin
      n.ctrl[rwu_pkg::RUN_BIT]  = 1'b0;
      n.ctrl[rwu_pkg::FLAG_BIT] = 1'b1;
      n.wdrst                   = 1'b1;
    end

    // stopped counter reads zero
    if (!n.ctrl[rwu_pkg::RUN_BIT]) begin
      n.cnt = '0;
    end

    // pin reset clears the whole watchdog
    if (ext_low) begin
      n.ctrl = rwu_pkg::CTRL_RST;
      n.osc  = rwu_pkg::OSC_RST;
      n.cnt  = '0;
    end

    // low-speed oscillator request, either owner keeps it on
    n.lsrun = n.osc[rwu_pkg::LS_START_BIT] |
              (~n.ctrl[rwu_pkg::CKSL_BIT] & n.ctrl[rwu_pkg::RUN_BIT] &
               ~paused);

    // reset sequencer, released only on the system clock
    restart = ext_low | wd_evt;
    case (r.seq)
      RWU_SEQ_HOLD: begin
        n.sysrst_n = 1'b0;
        n.medrc    = 1'b1;
        if (restart) begin
          n.hold = HOLD_LOAD;
        end else if (r.hold != '0) begin
          n.hold = r.hold - rwu_pkg::HOLD_W'(1);
        end else begin
          n.seq      = RWU_SEQ_RUN;
          n.sysrst_n = 1'b1;
          n.pc_load  = 1'b1;
          n.pc       = START_ADDR;
          n.sp       = rwu_pkg::SP_RST;
        end
      end
      RWU_SEQ_RUN: begin
        if (restart) begin
          n.seq      = RWU_SEQ_HOLD;
          n.hold     = HOLD_LOAD;
          n.sysrst_n = 1'b0;
          n.medrc    = 1'b1;
        end
      end
      default: begin
        n.seq      = RWU_SEQ_HOLD;
        n.hold     = HOLD_LOAD;
        n.sysrst_n = 1'b0;
      end
    endcase
    // no ram clear strobe exists; memory keeps its contents
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r.seq      <= RWU_SEQ_HOLD;
      r.hold     <= HOLD_LOAD;
      r.sysrst_n <= 1'b0;
      r.medrc    <= 1'b1;
      r.pc_load  <= 1'b0;
      r.pc       <= START_ADDR;
      r.sp       <= rwu_pkg::SP_RST;
      r.wdrst    <= 1'b0;
      r.ctrl     <= rwu_pkg::CTRL_RST;
      r.osc      <= rwu_pkg::OSC_RST;
      r.cnt      <= '0;
      r.ls_q     <= 1'b0;
      r.sb_q     <= 1'b0;
      r.stby_q   <= 1'b0;
      r.hold_q   <= 1'b0;
      r.lsrun    <= 1'b0;
      r.waitreq  <= 1'b1;
      r.rdata    <= '0;
      r.resp     <= rwu_pkg::RESP_OKAY;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign avs_readdata_o      = r.rdata;
  assign avs_response_o      = r.resp;
  assign avs_waitrequest_o   = r.waitreq;
  assign sys_rst_n_o         = r.sysrst_n;
  assign wdog_reset_o        = r.wdrst;
  assign force_medrc_o       = r.medrc;
  assign pc_load_o           = r.pc_load;
  assign pc_start_o          = r.pc;
  assign sp_init_o           = r.sp;
  assign lowspeed_osc_run_o  = r.lsrun;
  assign subclk_osc_enable_o = r.osc[rwu_pkg::SUB_EN_BIT];

endmodule
`default_nettype wire

// ### rtl/rwu_pkg.sv
// constants for the reset and watchdog unit
`default_nettype none
package rwu_pkg;

  // bus geometry
  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 16;
  localparam int          REG_W         = 8;
  localparam int          CNT_W         = 17;

  // register indices, byte address is four times the index
  localparam logic [15:0] CTRL_IDX      = 16'hfe79;
  localparam logic [15:0] KICK_IDX      = 16'hfe7a;
  localparam logic [15:0] OSC_IDX       = 16'hfe7b;
  localparam logic [15:0] CNT_IDX       = 16'hfe7c;

  // control register fields
  localparam int          FLAG_BIT      = 7;
  localparam int          CKSL_BIT      = 6;
  localparam int          RUN_BIT       = 5;
  localparam int          ACT_HI_BIT    = 4;
  localparam int          ACT_LO_BIT    = 3;
  localparam int          OVF_HI_BIT    = 2;
  localparam int          OVF_LO_BIT    = 0;

  // oscillator control fields
  localparam int          LS_START_BIT  = 0;
  localparam int          SUB_EN_BIT    = 6;

  // reset values and codes
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  OSC_RST       = 8'h00;
  localparam logic [7:0]  KICK_CODE     = 8'h55;
  localparam logic [1:0]  ACT_STOP      = 2'h1;
  localparam logic [1:0]  ACT_PAUSE     = 2'h2;
  localparam logic [17:0] OVF_BASE      = 18'h00400;
  localparam logic [15:0] SP_RST        = 16'h0000;

  // avalon response codes
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // timing
  localparam int          CLK_MHZ       = 125;
  localparam int          RST_HOLD_NS   = 128;
  localparam int          RST_HOLD_CYC  = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int          HOLD_W        = 5;

endpackage
`default_nettype wire

// ### rtl/rwu_sync.sv
// two-flop synchroniser bank for asynchronous inputs
`default_nettype none
module rwu_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rwu_sync_t;

  rwu_sync_t r;
  rwu_sync_t n;

  always_comb begin
    n    = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;

endmodule
`default_nettype wire

// ### test/rwu_top_monitor.sv
// concurrent checks on the reset and watchdog unit ports
`default_nettype none
module rwu_top_monitor #(
  parameter logic [15:0] START_ADDR = 16'h0000
) (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        ext_reset_n_pin_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        sys_rst_n_o,
  input wire logic        wdog_reset_o,
  input wire logic        force_medrc_o,
  input wire logic        pc_load_o,
  input wire logic [15:0] pc_start_o,
  input wire logic [15:0] sp_init_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_r;
  // cycles spent in functional reset
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) low_r <= 8'h00;
    else if (sys_rst_n_o) low_r <= 8'h00;
    else if (low_r != 8'hff) low_r <= low_r + 8'h01;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_pin_sync: assert property (
    (!ext_reset_n_pin_i) [*4] |-> !sys_rst_n_o) else $error("pin ignored");
  a_hold_len: assert property (
    $rose(sys_rst_n_o) |-> low_r >= 8'h10) else $error("hold short");
  a_medrc_sel: assert property (
    !sys_rst_n_o |-> force_medrc_o) else $error("medrc not forced");
  a_pc_start: assert property (
    $rose(sys_rst_n_o) |-> pc_load_o && pc_start_o == START_ADDR
    ##1 !pc_load_o) else $error("pc load wrong");
  a_pc_cause: assert property (
    pc_load_o |-> sys_rst_n_o && !$past(sys_rst_n_o))
    else $error("stray pc load");
  a_sp_zero: assert property (
    sp_init_o == 16'h0000) else $error("sp not zero");
  a_wdt_pulse: assert property (
    wdog_reset_o |=> !wdog_reset_o) else $error("wdt pulse long");
  a_wdt_reset: assert property (
    wdog_reset_o |-> !sys_rst_n_o) else $error("wdt no reset");
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer late");
  c_wdt: cover property (wdog_reset_o);
  c_rel: cover property ($rose(sys_rst_n_o));
  c_wr: cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind rwu_top rwu_top_monitor #(.START_ADDR(START_ADDR)) u_mon (
  .ref_clk_i, .rstn_i, .ext_reset_n_pin_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .sys_rst_n_o, .wdog_reset_o, .force_medrc_o,
  .pc_load_o, .pc_start_o, .sp_init_o);
`default_nettype wire

// ### test/rwu_osc_model.sv
// low-speed rc and subclock oscillator model
`default_nettype none
module rwu_osc_model (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic ls_run_i,
  input  wire logic sub_en_i,
  output logic      ls_clk_o,
  output logic      sub_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_r;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= 4'h0;
      ls_clk_o <= 1'b0;
      sub_clk_o <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      if (ls_run_i && div_r[1:0] == 2'h3) begin
        ls_clk_o <= ~ls_clk_o;
      end
      if (sub_en_i && div_r[2:0] == 3'h7) begin
        sub_clk_o <= ~sub_clk_o;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the reset and watchdog unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ctl = rwu_pkg::CTRL_IDX;
  localparam logic [15:0] kck = rwu_pkg::KICK_IDX;
  localparam logic [15:0] osc = rwu_pkg::OSC_IDX;
  localparam logic [15:0] cnt = rwu_pkg::CNT_IDX;
  logic        clk, rstn, pin, stby, rd_s, wr_s, wreq, srst, wrst;
  logic        lsrun, suben, ls_clk, sub_clk, ls_d, deep;
  logic [17:0] addr;
  logic [31:0] wdat, rdat, q, q2;
  logic [1:0]  resp, rs;
  int          n_errors = 0;
  int          tests_run = 0;
  int          ticks;
  rwu_top dut (
    .ref_clk_i(clk), .rstn_i(rstn), .ext_reset_n_pin_i(pin),
    .lowspeed_clk_i(ls_clk), .subclk_i(sub_clk), .standby_i(stby),
    .deep_standby_i(deep), .avs_address_i(addr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdat), .avs_response_o(resp),
    .avs_waitrequest_o(wreq), .sys_rst_n_o(srst), .wdog_reset_o(wrst),
    .force_medrc_o(), .pc_load_o(), .pc_start_o(), .sp_init_o(),
    .lowspeed_osc_run_o(lsrun), .subclk_osc_enable_o(suben));
  rwu_osc_model partner (
    .ref_clk_i(clk), .rstn_i(rstn), .ls_run_i(lsrun), .sub_en_i(suben),
    .ls_clk_o(ls_clk), .sub_clk_o(sub_clk));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] ix,
                     input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    wr_s <= w;
    rd_s <= ~w;
    addr <= {ix, 2'h0};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdat;
    rs = resp;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    if (n >= 40) chk("bus_wait", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    acc(1'b1, ix, d);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [31:0] e,
                    input string nm);
    acc(1'b0, ix, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wsys();
    int n = 0;
    while (srst !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("sys_release", 32'h1, {31'h0, srst === 1'b1});
  endtask
  task automatic wwd(input int lim);
    int n = 0;
    ticks = 0;
    ls_d = ls_clk;
    while (wrst !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
      if (ls_clk && !ls_d) ticks++;
      ls_d = ls_clk;
    end
    chk("wdt_pulse", 32'h1, {31'h0, wrst === 1'b1});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #600000;
    n_errors++;
    conclude();
  end
  initial begin
    rstn = 1'b0;
    pin = 1'b1;
    stby = 1'b0;
    deep = 1'b0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    addr = '0;
    wdat = '0;
    cyc(3);
    rstn <= 1'b1;
    wsys();
    rd(ctl, 32'h00, "ctrl_rst");
    rd(osc, 32'h00, "osc_rst");
    acc(1'b0, 16'h0000, 8'h00);
    chk("unmapped", {30'h0, rwu_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(osc, 8'h01);
    cyc(2);
    chk("ls_start", 32'h1, {31'h0, lsrun});
    wr(osc, 8'h00);
    $display("test reset done");
    wr(ctl, 8'h38);
    cyc(200);
    chk("ls_run", 32'h1, {31'h0, lsrun});
    wr(ctl, 8'h00);
    rd(ctl, 32'h38, "ctrl_lock");
    acc(1'b0, cnt, 8'h00);
    chk("cnt_resp", {30'h0, rwu_pkg::RESP_OKAY}, {30'h0, rs});
    q2 = q;
    chk("cnt_up", 32'h1, {31'h0, q2 != 32'h0});
    wr(ctl, 8'h55);
    acc(1'b0, cnt, 8'h00);
    chk("no_clear", 32'h1, {31'h0, q >= q2});
    wr(kck, 8'h55);
    wwd(10000);
    chk("ovf_ticks", 32'h1,
        {31'h0, ticks >= 1022 && ticks <= 1025});
    rd(ctl, 32'h98, "ctrl_wdt");
    wsys();
    wr(ctl, 8'h39);
    wwd(20000);
    chk("ovf_ticks2", 32'h1,
        {31'h0, ticks >= 2046 && ticks <= 2049});
    rd(ctl, 32'h99, "ctrl_wdt2");
    wsys();
    $display("test lowspeed done");
    wr(osc, 8'h40);
    wr(ctl, 8'h60);
    cyc(100);
    chk("sub_en", 32'h1, {31'h0, suben});
    acc(1'b0, cnt, 8'h00);
    chk("sub_cnt", 32'h1, {31'h0, q != 32'h0});
    wr(osc, 8'h00);
    wwd(40);
    rd(ctl, 32'hc0, "ctrl_sub");
    wsys();
    wr(osc, 8'h40);
    wr(ctl, 8'h60);
    cyc(20);
    deep <= 1'b1;
    wwd(40);
    rd(ctl, 32'hc0, "ctrl_deep");
    deep <= 1'b0;
    wsys();
    $display("test subclock done");
    wr(ctl, 8'h28);
    rd(ctl, 32'h28, "flag_sw");
    cyc(50);
    stby <= 1'b1;
    cyc(10);
    rd(ctl, 32'h08, "stop_act");
    rd(cnt, 32'h0, "cnt_stop");
    stby <= 1'b0;
    wr(ctl, 8'h30);
    cyc(100);
    stby <= 1'b1;
    cyc(20);
    acc(1'b0, cnt, 8'h00);
    q2 = q;
    cyc(200);
    rd(cnt, q2, "cnt_pause");
    stby <= 1'b0;
    cyc(100);
    acc(1'b0, cnt, 8'h00);
    chk("cnt_resume", 32'h1, {31'h0, q > q2});
    $display("test standby done");
    pin <= 1'b0;
    cyc(10);
    pin <= 1'b1;
    wsys();
    rd(ctl, 32'h00, "ctrl_pin");
    $display("test pin done");
    conclude();
  end
endmodule
`default_nettype wire
